// ===== verilog/encoder_preset_scaling_unit.sv
`timescale 1ns/1ns
module encoder_preset_scaling_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Holding register port
  input wire preset_scaling_pkg::reg_write_t reg_write,
  input wire logic [7:0] reg_rd_addr,
  output logic [15:0] reg_rd_data,
  // Position path
  input wire logic [25:0] raw_position,
  output logic [31:0] position_out,
  output logic [15:0] status_word
);

  logic [31:0] cpr;
  logic [31:0] total;
  logic [31:0] home_target_value;
  logic [31:0] captured_home_position;
  logic [15:0] counting_configuration;
  logic [15:0] command_register;
  logic [15:0] next_command;
  logic [31:0] read_position;
  logic home_edge;
  logic defaults_edge;
  preset_scaling_pkg::count_mode_t mode;

  // ******************************************************************
  // Command decode
  // ******************************************************************
  always_comb begin
    next_command = command_register;
    if (reg_write.wr_en && reg_write.addr == preset_scaling_pkg::IDX_COMMAND) begin
      next_command = reg_write.data & preset_scaling_pkg::COMMAND_MASK;
    end
    home_edge = next_command[preset_scaling_pkg::BIT_HOME] &&
      !command_register[preset_scaling_pkg::BIT_HOME];
    defaults_edge = next_command[preset_scaling_pkg::BIT_LOAD_DEFAULTS] &&
      !command_register[preset_scaling_pkg::BIT_LOAD_DEFAULTS];
    mode.scale_en = counting_configuration[preset_scaling_pkg::BIT_SCALE_EN];
    mode.dir_ccw = counting_configuration[preset_scaling_pkg::BIT_DIR_CCW];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      command_register <= preset_scaling_pkg::DEFAULT_COMMAND;
    end else begin
      command_register <= next_command;
    end
  end

  // ******************************************************************
  // Parameter registers
  // ******************************************************************
  // A defaults restore takes priority over a data write in the same cycle, since
  // the restore is meant to overwrite everything set before it.
  always_ff @(posedge clk) begin
    if (rst || defaults_edge) begin
      cpr <= preset_scaling_pkg::DEFAULT_CPR;
      total <= preset_scaling_pkg::DEFAULT_TOTAL;
      home_target_value <= preset_scaling_pkg::DEFAULT_HOME_TARGET;
      counting_configuration <= preset_scaling_pkg::DEFAULT_CONFIG;
    end else if (reg_write.wr_en) begin
      case (reg_write.addr)
        preset_scaling_pkg::IDX_CPR_HI: cpr[31:16] <= reg_write.data;
        preset_scaling_pkg::IDX_CPR_LO: cpr[15:0] <= reg_write.data;
        preset_scaling_pkg::IDX_TOTAL_HI: total[31:16] <= reg_write.data;
        preset_scaling_pkg::IDX_TOTAL_LO: total[15:0] <= reg_write.data;
        preset_scaling_pkg::IDX_HOME_TARGET_HI: home_target_value[31:16] <= reg_write.data;
        preset_scaling_pkg::IDX_HOME_TARGET_LO: home_target_value[15:0] <= reg_write.data;
        preset_scaling_pkg::IDX_CONFIG: begin
          counting_configuration <= reg_write.data & preset_scaling_pkg::CONFIG_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // The captured position has no write path at all, so a master write to its
  // indices is silently dropped.
  always_ff @(posedge clk) begin
    if (rst || defaults_edge) begin
      captured_home_position <= preset_scaling_pkg::DEFAULT_CAPTURED;
    end else if (home_edge) begin
      captured_home_position <= read_position;
    end
  end

  // ******************************************************************
  // Position path
  // ******************************************************************
  position_scaler scaler (
    .clk(clk),
    .rst(rst),
    .mode(mode),
    .cpr(cpr),
    .total(total),
    .raw_position(raw_position),
    .read_position(read_position)
  );

  // The homed cycle itself already shows the target value, because the home edge loads
  // home_target_value straight into position_out instead of the sum with the capture.
  always_ff @(posedge clk) begin
    if (rst) begin
      position_out <= 32'h0000_0000;
    end else if (home_edge) begin
      position_out <= home_target_value;
    end else begin
      position_out <= read_position + home_target_value - captured_home_position;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_word <= 16'h0000;
    end else begin
      status_word <= 16'(counting_configuration & preset_scaling_pkg::CONFIG_MASK);
    end
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rd_data <= 16'h0000;
    end else begin
      case (reg_rd_addr)
        preset_scaling_pkg::IDX_CPR_HI: reg_rd_data <= cpr[31:16];
        preset_scaling_pkg::IDX_CPR_LO: reg_rd_data <= cpr[15:0];
        preset_scaling_pkg::IDX_TOTAL_HI: reg_rd_data <= total[31:16];
        preset_scaling_pkg::IDX_TOTAL_LO: reg_rd_data <= total[15:0];
        preset_scaling_pkg::IDX_HOME_TARGET_HI: reg_rd_data <= home_target_value[31:16];
        preset_scaling_pkg::IDX_HOME_TARGET_LO: reg_rd_data <= home_target_value[15:0];
        preset_scaling_pkg::IDX_CAPTURED_HI: reg_rd_data <= captured_home_position[31:16];
        preset_scaling_pkg::IDX_CAPTURED_LO: reg_rd_data <= captured_home_position[15:0];
        preset_scaling_pkg::IDX_CONFIG: reg_rd_data <= counting_configuration;
        preset_scaling_pkg::IDX_COMMAND: reg_rd_data <= command_register;
        preset_scaling_pkg::IDX_STATUS: reg_rd_data <= status_word;
        default: reg_rd_data <= 16'h0000;
      endcase
    end
  end

endmodule : encoder_preset_scaling_unit

// ===== verilog/preset_scaling_pkg.sv
// Behaviour
// - Output position is read position plus home target value minus captured home position.
// - A homing command copies the current read position into the captured home position.
// - The position present at a homing command is from then on output as the home target.
// - The home target value is a 32-bit read-write value, reset to 0, holding 0 to 67108864.
// - The captured home position is read-only, resets to 0 and is cleared only by a restore.
// - Configuration bit 0 clear selects the hardware resolution, set the programmed ones.
// - Scaled position is position times programmed over hardware counts per turn, mod total.
// - Configuration bit 1 at 0 counts up clockwise, at 1 counts up counter-clockwise.
// - Status bit 0 mirrors the scaling enable and status bit 1 mirrors the direction setting.
// - The command register is 16-bit read-write, acts at once and has an unused low byte.
// - Homing is triggered only by a rising edge of command bit 11.
// - A rising edge of command bit 10 restores every parameter to its factory default.
package preset_scaling_pkg;

  // ******************************************************************
  // Register word indices (one 16-bit holding register each)
  // ******************************************************************
  localparam logic [7:0] IDX_CPR_HI = 8'h00;
  localparam logic [7:0] IDX_CPR_LO = 8'h01;
  localparam logic [7:0] IDX_TOTAL_HI = 8'h02;
  localparam logic [7:0] IDX_TOTAL_LO = 8'h03;
  localparam logic [7:0] IDX_HOME_TARGET_HI = 8'h04;
  localparam logic [7:0] IDX_HOME_TARGET_LO = 8'h05;
  localparam logic [7:0] IDX_CAPTURED_HI = 8'h06;
  localparam logic [7:0] IDX_CAPTURED_LO = 8'h07;
  localparam logic [7:0] IDX_CONFIG = 8'h08;
  localparam logic [7:0] IDX_COMMAND = 8'h09;
  localparam logic [7:0] IDX_STATUS = 8'h0A;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int BIT_SCALE_EN = 0;
  localparam int BIT_DIR_CCW = 1;
  localparam int BIT_LOAD_DEFAULTS = 10;
  localparam int BIT_HOME = 11;
  localparam logic [15:0] CONFIG_MASK = 16'h0003;
  localparam logic [15:0] COMMAND_MASK = 16'hFF00;

  // ******************************************************************
  // Resolutions and defaults
  // ******************************************************************
  localparam int HW_CPR_BITS = 12;
  localparam int HW_TOTAL_BITS = 26;
  localparam logic [31:0] HW_TOTAL = 32'h0400_0000;
  localparam logic [31:0] DEFAULT_CPR = 32'h0000_1000;
  localparam logic [31:0] DEFAULT_TOTAL = 32'h0400_0000;
  localparam logic [31:0] DEFAULT_HOME_TARGET = 32'h0000_0000;
  localparam logic [31:0] DEFAULT_CAPTURED = 32'h0000_0000;
  localparam logic [15:0] DEFAULT_CONFIG = 16'h0000;
  localparam logic [15:0] DEFAULT_COMMAND = 16'h0000;

  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [15:0] data;
  } reg_write_t;

  typedef struct packed {
    logic scale_en;
    logic dir_ccw;
  } count_mode_t;

endpackage : preset_scaling_pkg

// ===== verilog/position_scaler.sv
`timescale 1ns/1ns
module position_scaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings
  input wire preset_scaling_pkg::count_mode_t mode,
  input wire logic [31:0] cpr,
  input wire logic [31:0] total,
  // Sensor position and result
  input wire logic [25:0] raw_position,
  output logic [31:0] read_position
);

  logic [25:0] directed;
  logic [57:0] product;
  logic [31:0] scaled;

  // Mirroring the count modulo the hardware range turns a clockwise sensor into a
  // counter-clockwise one without a discontinuity other than the natural wrap.
  always_comb begin
    directed = mode.dir_ccw ? 26'(-raw_position) : raw_position;
    product = 58'(directed) * 58'(cpr);
    scaled = 32'(product >> preset_scaling_pkg::HW_CPR_BITS);
  end

  // The remainder keeps the scaled count inside the programmed range; a zero range is
  // never legal, so it falls back to the unbounded value instead of dividing by zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      read_position <= 32'h0000_0000;
    end else if (!mode.scale_en) begin
      read_position <= 32'(directed);
    end else if (total != 32'h0000_0000) begin
      read_position <= scaled % total;
    end else begin
      read_position <= scaled;
    end
  end

endmodule : position_scaler

// ===== tb/preset_scaling_props.sv
`timescale 1ns/1ns
module preset_scaling_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire preset_scaling_pkg::reg_write_t reg_write,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [15:0] reg_rd_data,
  input wire logic [25:0] raw_position,
  input wire logic [31:0] position_out,
  input wire logic [15:0] status_word
);
  logic prev_ld;
  wire cmd_wr = reg_write.wr_en && reg_write.addr == preset_scaling_pkg::IDX_COMMAND;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Restore acts on a rising bit, so the last written level is kept here.
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ld <= 1'b0;
    end else if (cmd_wr) begin
      prev_ld <= reg_write.data[10];
    end
  end
  sequence cfg_wr;
    reg_write.wr_en && reg_write.addr == preset_scaling_pkg::IDX_CONFIG;
  endsequence
  sequence ld_rise;
    cmd_wr && reg_write.data[10] && !prev_ld;
  endsequence
  sequence quiet;
    (!reg_write.wr_en && $stable(raw_position))[*4];
  endsequence
  property p_mirror;
    cfg_wr |-> ##2 status_word[1:0] == $past(reg_write.data[1:0], 2);
  endproperty
  a_reset_clears: assert property (disable iff (1'b0) rst |=> status_word == 16'h0000
    && position_out == 32'h0000_0000) else $error("outputs not cleared by reset");
  a_status_mirror: assert property (p_mirror) else $error("status does not mirror mode");
  a_status_unused: assert property (status_word[15:2] == 14'h0000)
    else $error("status upper bits set");
  a_config_unused: assert property ($past(reg_rd_addr) == preset_scaling_pkg::IDX_CONFIG
    |-> reg_rd_data[15:2] == 14'h0000) else $error("config unused bits read nonzero");
  a_cmd_low_byte: assert property ($past(reg_rd_addr) == preset_scaling_pkg::IDX_COMMAND
    |-> reg_rd_data[7:0] == 8'h00) else $error("command low byte read nonzero");
  a_restore_mode: assert property (ld_rise |-> ##[1:2] status_word[1:0] == 2'b00)
    else $error("restore left mode set");
  a_hold_position: assert property (quiet |-> $stable(position_out))
    else $error("position moved while idle");
  a_status_ro: assert property (reg_write.wr_en && reg_write.addr == 8'h0A
    && !$past(reg_write.wr_en) |=> $stable(status_word)) else $error("status was written");
endmodule : preset_scaling_props
bind encoder_preset_scaling_unit preset_scaling_props i_props (.clk(clk), .rst(rst),
  .reg_write(reg_write), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
  .raw_position(raw_position), .position_out(position_out), .status_word(status_word));

// ===== tb/bus_master_model.sv
`timescale 1ns/1ns
module bus_master_model (
  // Clock
  input wire logic clk,
  // Holding register port
  output preset_scaling_pkg::reg_write_t reg_write,
  output logic [7:0] reg_rd_addr,
  input wire logic [15:0] reg_rd_data
);
  initial begin
    reg_write = '0;
    reg_rd_addr = 8'h00;
  end
  // Released lines show inverted values so a stale match cannot hide a fault.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_write <= '{1'b1, a, d};
    @(negedge clk);
    reg_write <= '{1'b0, ~a, ~d};
    repeat ($urandom_range(1, 0)) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_rd_addr <= a;
    @(negedge clk);
    d = reg_rd_data;
  endtask : rd
endmodule : bus_master_model

// ===== tb/encoder_preset_scaling_unit_bench.sv
`timescale 1ns/1ns
module encoder_preset_scaling_unit_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [25:0] raw = 26'h0;
  logic [15:0] d;
  logic [31:0] tgt;
  logic [31:0] cap;
  logic [31:0] pos_out;
  logic [15:0] status;
  logic [7:0] rd_addr;
  logic [15:0] rd_data;
  preset_scaling_pkg::reg_write_t wr_bus;
  logic [15:0] dflt [0:8] = '{16'h0000, 16'h1000, 16'h0400, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int n_errors = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  bus_master_model i_master (.clk(clk), .reg_write(wr_bus), .reg_rd_addr(rd_addr),
    .reg_rd_data(rd_data));
  encoder_preset_scaling_unit i_dut (.clk(clk), .rst(rst), .reg_write(wr_bus),
    .reg_rd_addr(rd_addr), .reg_rd_data(rd_data), .raw_position(raw),
    .position_out(pos_out), .status_word(status));
  function automatic logic [31:0] exp_pos(input logic [25:0] r, input logic [1:0] m);
    logic [25:0] dir_r;
    logic [63:0] v;
    dir_r = m[1] ? 26'h0 - r : r;
    v = 64'(dir_r);
    if (m[0]) v = ((v * 64'h800) >> 12) % 64'h20_0000;
    return v[31:0] + tgt - cap;
  endfunction : exp_pos
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    i_master.rd(a, d);
    chk(32'(d), 32'(exp));
  endtask : rchk
  task automatic pchk(input logic [31:0] exp);
    repeat (3) @(negedge clk);
    chk(pos_out, exp);
  endtask : pchk
  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(29));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    foreach (dflt[i]) rchk(8'(i), dflt[i]);
    tgt = 32'h0;
    cap = 32'h0;
    for (int i = 0; i < 20; i++) begin
      raw = 26'($urandom);
      pchk(32'(raw));
    end
    tgt = $urandom_range(32'd67108864);
    i_master.wr(8'h04, tgt[31:16]);
    i_master.wr(8'h05, tgt[15:0]);
    rchk(8'h04, tgt[31:16]);
    rchk(8'h05, tgt[15:0]);
    cap = 32'(raw);
    i_master.wr(8'h09, 16'h08FF);
    rchk(8'h07, cap[15:0]);
    rchk(8'h09, 16'h0800);
    pchk(tgt);
    i_master.wr(8'h06, 16'hFFFF);
    rchk(8'h06, cap[31:16]);
    raw = raw + 26'd5;
    i_master.wr(8'h09, 16'h0800);
    rchk(8'h07, cap[15:0]);
    pchk(exp_pos(raw, 2'b00));
    i_master.wr(8'h01, 16'h0800);
    i_master.wr(8'h02, 16'h0020);
    i_master.wr(8'h0A, 16'hFFFF);
    for (int m = 0; m < 4; m++) begin
      i_master.wr(8'h08, 16'(m) | 16'hFFFC);
      rchk(8'h08, 16'(m));
      chk(32'(status), 32'(m));
      raw = 26'($urandom);
      pchk(exp_pos(raw, 2'(m)));
    end
    i_master.wr(8'h09, 16'h0000);
    i_master.wr(8'h09, 16'h0800);
    cap = exp_pos(raw, 2'b11) - tgt + cap;
    pchk(tgt);
    i_master.wr(8'h09, 16'h0400);
    foreach (dflt[i]) rchk(8'(i), dflt[i]);
    chk(32'(status), 32'h0);
    report_and_stop();
  end
endmodule : encoder_preset_scaling_unit_bench
